// [hdl/pcat_consts.vh]
`ifndef PCAT_CONSTS_VH
`define PCAT_CONSTS_VH

// ----------------------------------------
// Configuration register offsets
// ----------------------------------------
`define PCAT_OFS_REQ_IGNORE 8'hDD
`define PCAT_OFS_EXPIRY 8'hDE

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PCAT_BIT_WDOG_EN 7
`define PCAT_BIT_AUTO_MASK 6
`define PCAT_IGNORE_RESET 8'h00
`define PCAT_EXPIRY_RESET 6'h00
`define PCAT_RSVD_EXPIRY 2'h0
`define PCAT_RDATA_IDLE 8'h00

// ----------------------------------------
// Request lines and watchdog timing
// ----------------------------------------
`define PCAT_NREQ 6
`define PCAT_NREQ_ALL 6'h3F
`define PCAT_IDX_RESET 3'h5
`define PCAT_IDX_LAST 3'h5
`define PCAT_WDOG_CLKS 5'h10
`define PCAT_CNT_ZERO 5'h00
`define PCAT_CNT_ONE 5'h01
`define PCAT_SYNC_IDLE 8'hFF
`define PCAT_SYNC_WIDTH 8
`define PCAT_PIN_FRAME 6
`define PCAT_PIN_IRDY 7
`define PCAT_GNT_LSB 6'h01
`define PCAT_RR_FIRST 1
`define PCAT_RR_CLEAR 0

`endif

// [hdl/pcat_sync.v]
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for pin inputs; first stage feeds only the second
module pcat_sync #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Pin side and synchronised side
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	// Reset to the idle level so nothing looks active at release
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= IDLE;
			sync_out <= IDLE;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// [hdl/pcat_arbiter.v]
`timescale 1ns/1ps
`default_nettype none
`include "pcat_consts.vh"

// Behaviour
// - With watchdog enabled, grant expires after 16 idle clocks without FRAME.
// - With watchdog cleared, the default, no expiry is ever detected.
// - Auto-mask bit set: expired request line gets its ignore bit set.
// - Ignore bits 5..0 remove matching request from arbitration entirely.
// - All control bits return to defaults on any reset source.
// - Expiry flag set for the line whose master missed FRAME.
// - Expiry register resets to 00h; flags stay until software clears.
// - Expiry bits 5..0 per line, bits 7:6 read as zero.
module pcat_arbiter (
	// Clock and combined link, pin and power-on reset
	input wire clk,
	input wire reset,
	// Configuration access
	input wire [7:0] cfg_addr,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_wdata,
	output reg [7:0] cfg_rdata,
	// Secondary bus pins
	input wire [5:0] req_n,
	input wire frame_n,
	input wire irdy_n,
	output reg [5:0] gnt_n
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_GRANTED = 2'b01;
	localparam [1:0] ST_BUSY = 2'b10;

	// ----------------------------------------
	// Registers and their next values
	// ----------------------------------------
	reg [1:0] state_reg, state_next;
	reg [7:0] ignore_reg, ignore_next;
	reg [5:0] expiry_reg, expiry_next;
	reg [2:0] owner_reg, owner_next;
	reg [4:0] wdog_cnt_reg, wdog_cnt_next;
	reg [5:0] gnt_n_next;
	reg [7:0] rdata_next;
	wire [7:0] pins_sync;
	wire [5:0] req_sync;
	wire bus_idle;
	wire frame_seen;
	wire [5:0] req_active;
	reg pick_found;
	reg [2:0] pick_idx;
	reg expire;
	// Loop variables of the round-robin search
	integer i;
	integer j;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	// Frame and IRDY share the requests' synchroniser so all pins line up
	pcat_sync #(
		.WIDTH(`PCAT_SYNC_WIDTH),
		.IDLE(`PCAT_SYNC_IDLE)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.pin_in({irdy_n, frame_n, req_n}),
		.sync_out(pins_sync)
	);

	// Active-high views of the synchronised pins
	assign req_sync = ~pins_sync[5:0];
	assign frame_seen = ~pins_sync[`PCAT_PIN_FRAME];
	assign bus_idle = pins_sync[`PCAT_PIN_FRAME] & pins_sync[`PCAT_PIN_IRDY];

	assign req_active = req_sync & ~ignore_reg[5:0];

	// ----------------------------------------
	// Round-robin pick, starting after the last owner
	// ----------------------------------------
	always @* begin
		pick_found = 1'b0;
		pick_idx = owner_reg;
		j = `PCAT_RR_CLEAR;
		// Owner itself is tried last, so one master cannot hold the bus
		for (i = `PCAT_RR_FIRST; i <= `PCAT_NREQ; i = i + 1) begin
			j = owner_reg + i;
			if (j >= `PCAT_NREQ) begin
				j = j - `PCAT_NREQ;
			end
			if (!pick_found && req_active[j]) begin
				pick_found = 1'b1;
				pick_idx = j[2:0];
			end
		end
	end

	// ----------------------------------------
	// Grant state machine and watchdog
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		owner_next = owner_reg;
		wdog_cnt_next = wdog_cnt_reg;
		gnt_n_next = gnt_n;
		expire = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// Cleared so every new grant gets the full watchdog span
				wdog_cnt_next = `PCAT_CNT_ZERO;
				if (pick_found && bus_idle) begin
					owner_next = pick_idx;
					gnt_n_next = ~(`PCAT_GNT_LSB << pick_idx);
					state_next = ST_GRANTED;
				end
			end
			ST_GRANTED: begin
				if (frame_seen) begin
					// Transaction started; release grant for the next round
					gnt_n_next = `PCAT_NREQ_ALL;
					state_next = ST_BUSY;
				end else if (!req_active[owner_reg]) begin
					// Request withdrawn or masked while waiting
					gnt_n_next = `PCAT_NREQ_ALL;
					state_next = ST_IDLE;
				end else if (ignore_reg[`PCAT_BIT_WDOG_EN] && bus_idle) begin
					wdog_cnt_next = wdog_cnt_reg + `PCAT_CNT_ONE;
					if (wdog_cnt_next == `PCAT_WDOG_CLKS) begin
						expire = 1'b1;
						gnt_n_next = `PCAT_NREQ_ALL;
						// Owner kept, so the search resumes past the silent line
						state_next = ST_IDLE;
					end
				end else begin
					wdog_cnt_next = `PCAT_CNT_ZERO;
				end
			end
			ST_BUSY: begin
				// Wait for a synced idle bus; a back-to-back frame must not look free
				wdog_cnt_next = `PCAT_CNT_ZERO;
				if (bus_idle) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				// Unused code: drop any grant and start over
				gnt_n_next = `PCAT_NREQ_ALL;
				state_next = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Register writes; hardware set beats software write
	// ----------------------------------------
	always @* begin
		ignore_next = ignore_reg;
		expiry_next = expiry_reg;
		if (cfg_wr && cfg_addr == `PCAT_OFS_REQ_IGNORE) begin
			ignore_next = cfg_wdata;
		end else if (cfg_wr && cfg_addr == `PCAT_OFS_EXPIRY) begin
			expiry_next = expiry_reg & ~cfg_wdata[5:0];
		end
		if (expire) begin
			expiry_next[owner_reg] = 1'b1;
			// optional automatic mask
			// Hardware set also beats a same-cycle software write
			if (ignore_reg[`PCAT_BIT_AUTO_MASK]) begin
				ignore_next[owner_reg] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read data, registered one clock after the strobe
	// ----------------------------------------
	always @* begin
		// Unmapped addresses and idle cycles read as zero
		rdata_next = `PCAT_RDATA_IDLE;
		if (cfg_rd && cfg_addr == `PCAT_OFS_REQ_IGNORE) begin
			rdata_next = ignore_reg;
		end else if (cfg_rd && cfg_addr == `PCAT_OFS_EXPIRY) begin
			rdata_next = {`PCAT_RSVD_EXPIRY, expiry_reg};
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	// every control bit back to default on reset
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			ignore_reg <= `PCAT_IGNORE_RESET;
			expiry_reg <= `PCAT_EXPIRY_RESET;
			owner_reg <= `PCAT_IDX_RESET;
			wdog_cnt_reg <= `PCAT_CNT_ZERO;
			gnt_n <= `PCAT_NREQ_ALL;
			cfg_rdata <= `PCAT_RDATA_IDLE;
		end else begin
			state_reg <= state_next;
			ignore_reg <= ignore_next;
			expiry_reg <= expiry_next;
			owner_reg <= owner_next;
			wdog_cnt_reg <= wdog_cnt_next;
			gnt_n <= gnt_n_next;
			cfg_rdata <= rdata_next;
		end
	end

endmodule

`default_nettype wire

// [verification/pcat_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pcat_props (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Configuration access
	input wire [7:0] cfg_addr,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_wdata,
	input wire [7:0] cfg_rdata,
	// Bus pins
	input wire [5:0] req_n,
	input wire frame_n,
	input wire irdy_n,
	input wire [5:0] gnt_n
);
	logic [7:0] sh_reg;
	logic [5:0] idle_reg;
	// Shadow of the last control write; hardware only ever adds ignore bits
	always @(posedge clk or posedge reset)
		if (reset)
			sh_reg <= 8'h00;
		else if (cfg_wr && cfg_addr == 8'hDD)
			sh_reg <= cfg_wdata;
	// Idle cycles under one grant; pins lead the synchroniser, so it may count long
	always @(posedge clk or posedge reset)
		if (reset)
			idle_reg <= 6'h00;
		else if (sh_reg[7] && gnt_n != 6'h3F && frame_n && irdy_n)
			idle_reg <= idle_reg + 6'h01;
		else
			idle_reg <= 6'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_ONEHOT: assert property ($onehot0(~gnt_n)) else $error("two grants low");
	AST_RDIDLE: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00) else $error("read data not idle");
	AST_RSVD: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'hDE |-> cfg_rdata[7:6] == 2'h0)
		else $error("reserved bits set");
	AST_UNMAP: assert property ($past(cfg_rd) && $past(cfg_addr) != 8'hDD && $past(cfg_addr) != 8'hDE
		|-> cfg_rdata == 8'h00) else $error("unmapped read not zero");
	AST_REQ: assert property ((~gnt_n & $past(gnt_n)) != 6'h00 |-> (~gnt_n & $past(req_n, 3)) == 6'h00)
		else $error("grant without request");
	AST_MASK: assert property ((~gnt_n & $past(gnt_n)) != 6'h00 |-> (~gnt_n & $past(sh_reg[5:0])) == 6'h00)
		else $error("grant on ignored line");
	AST_FRAME: assert property (!$past(frame_n, 3) |-> gnt_n == 6'h3F) else $error("grant held in frame");
	AST_WDOG: assert property (idle_reg <= 6'd17) else $error("grant outlived watchdog");
	AST_CTRL: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'hDD |-> cfg_rdata[7:6] == $past(sh_reg[7:6]))
		else $error("control bits wrong");
	cover property (gnt_n != 6'h3F);
	cover property (idle_reg == 6'd15);
	cover property ($past(cfg_rd) && cfg_rdata != 8'h00);
endmodule
`default_nettype wire

// [verification/pcat_masters.sv]
`timescale 1ns/1ps
`default_nettype none
module pcat_masters (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Bench control
	input wire [5:0] want,
	input wire answer,
	// Bus pins
	input wire [5:0] gnt_n,
	output logic [5:0] req_n,
	output logic frame_n,
	output logic irdy_n
);
	assign req_n = ~want;
	assign irdy_n = frame_n;
	// A granted master starts its frame next cycle, only if told to answer
	always @(posedge clk or posedge reset)
		if (reset)
			frame_n <= 1'b1;
		else
			frame_n <= !(answer && gnt_n != 6'h3F);
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, reset, cfg_wr, cfg_rd, answer, frame_n, irdy_n;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, g, m;
	logic [5:0] want, req_n, gnt_n;
	int fail_count, compares, cyc, n, k, ign, flg;
	pcat_arbiter uut (.clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n),
		.gnt_n(gnt_n));
	pcat_masters far (.clk(clk), .reset(reset), .want(want), .answer(answer), .gnt_n(gnt_n), .req_n(req_n),
		.frame_n(frame_n), .irdy_n(irdy_n));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			final_report;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cfg_wr <= 1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr <= 0;
		if (a == 8'hDD) ign = d;
		if (a == 8'hDE) flg = flg & ~d;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		cfg_rd <= 1;
		cfg_addr <= a;
		@(posedge clk);
		cfg_rd <= 0;
		#1 chk(cfg_rdata, e);
	endtask
	task final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		answer = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 8'h00;
		want = 6'h00;
		void'($urandom(32'h2454));
		repeat (8) @(posedge clk);
		reset <= 0;
		rd(8'hDD, 8'h00);
		rd(8'hDE, 8'h00);
		rd(8'hE0 | 8'($urandom % 16), 8'h00);
		$display("reset test done");
		// Random ignore set, line 0 always left open
		m = 8'($urandom) & 8'h3E;
		wr(8'hDD, m);
		want <= 6'h3F;
		answer <= 1;
		g = 0;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			#1 g = g | {2'h0, ~gnt_n};
		end
		chk(g & m, 8'h00);
		chk(8'(g != 0), 8'h01);
		$display("mask test done");
		// Silent master on a random line
		@(posedge clk);
		want <= 0;
		answer <= 0;
		n = $urandom % 6;
		wr(8'hDD, 8'hC0);
		repeat (6) @(posedge clk);
		want <= 6'(1 << n);
		for (k = 0; k < 40 && gnt_n[n] !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		for (k = 0; k < 40 && gnt_n[n] === 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		chk(8'(k), 8'h10);
		flg = flg | (1 << n);
		rd(8'hDD, 8'(ign | (1 << n)));
		rd(8'hDE, 8'(flg));
		chk({2'h0, gnt_n}, 8'h3F);
		wr(8'hDE, 8'(1 << n));
		rd(8'hDE, 8'(flg));
		$display("watchdog test done");
		// Watchdog off: grant simply stays
		wr(8'hDD, 8'h00);
		repeat (40) @(posedge clk);
		rd(8'hDE, 8'h00);
		chk({7'h0, gnt_n[n]}, 8'h00);
		wr(8'hDD, 8'h45);
		reset <= 1;
		ign = 0;
		flg = 0;
		#1 chk({2'h0, gnt_n}, 8'h3F);
		repeat (2) @(posedge clk);
		reset <= 0;
		rd(8'hDD, 8'(ign));
		rd(8'hDE, 8'(flg));
		$display("second reset test done");
		final_report;
	end
endmodule
bind pcat_arbiter pcat_props chk (.clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .req_n(req_n), .frame_n(frame_n),
	.irdy_n(irdy_n), .gnt_n(gnt_n));
`default_nettype wire
